// [src/plk_write_lock.sv]
// module: apb register write lock with key sequence and locked groups
// What this block does
// R1: one lock bit guards each peripheral group
// R2: lock bits change only after ordered key sequence
// R3: any key write after unlock relocks
// R4: key read returns unlocked state
// R5: writes to locked group silently dropped
// R6: peripheral reads always answer with contents
// R7: wrong key value restarts sequence, stays locked
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module plk_write_lock
(
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    input  wire plk_pkg::plk_apb_req_s       apb_req,
    output logic                             pready,
    output logic                             pslverr,
    output logic [plk_pkg::DW-1:0]           prdata,
    output logic [plk_pkg::NGROUP-1:0]       peripheral_group_lock_bits,
    output logic                             lock_bits_open,
    output logic [plk_pkg::NPER-1:0][31:0]   periph_regs
);
    // ********************************************
    // state
    // ********************************************
    plk_pkg::plk_state_s st_r;
    plk_pkg::plk_state_s st_nxt;
    logic                acc;
    logic                done;
    logic                is_key;
    logic                is_lock;
    logic                is_per;
    logic [11:0]         per_off;
    logic [2:0]          per_idx;
    logic [1:0]          per_grp;

    assign acc     = apb_req.psel & apb_req.penable & ~st_r.pready;
    assign done    = apb_req.psel & apb_req.penable & st_r.pready;
    assign is_key  = apb_req.paddr == plk_pkg::KEY_OFS;
    assign is_lock = apb_req.paddr == plk_pkg::LOCK_OFS;
    assign per_off = apb_req.paddr - plk_pkg::PER_OFS;
    assign is_per  = apb_req.paddr >= plk_pkg::PER_OFS
                     && per_off < 12'(plk_pkg::NPER * 4);
    assign per_idx = per_off[4:2];
    // two registers per group, so the group is the upper index bits
    assign per_grp = per_idx[2:1];
    // decode is plain compare; the address must not move during access,
    // since the write is applied at the completing edge, not when latched

    // ********************************************
    // next state
    // ********************************************
    always_comb
    begin
        st_nxt = st_r;
        // answer one cycle into the access phase, so outputs stay registered
        if (acc)
        begin
            st_nxt.pready  = 1'b1;
            st_nxt.pslverr = ~(is_key | is_lock | is_per);
            st_nxt.prdata  = '0;
            if (is_key)
                st_nxt.prdata = {31'h0, st_r.unl}; // R4
            else if (is_lock)
                st_nxt.prdata = {28'h0, st_r.lock};
            else if (is_per)
                st_nxt.prdata = st_r.regs[per_idx]; // R6
        end
        if (done)
        begin
            st_nxt.pready  = 1'b0;
            st_nxt.pslverr = 1'b0;
            if (apb_req.pwrite)
            begin
                if (is_key)
                begin
                    if (st_r.unl)
                    begin
                        st_nxt.unl = 1'b0; // R3
                        st_nxt.idx = '0;
                    end
                    else if (apb_req.pwdata[7:0] == plk_pkg::KEY_SEQ[st_r.idx])
                    begin
                        if (st_r.idx == 2'(plk_pkg::KEY_LEN - 1))
                        begin
                            st_nxt.unl = 1'b1; // R2
                            st_nxt.idx = '0;
                        end
                        else
                            st_nxt.idx = st_r.idx + 2'h1; // R2
                    end
                    else
                        st_nxt.idx = '0; // R7
                end
                // a closed lock register ignores writes with no error, so
                // firmware cannot probe the lock state by bus faults
                else if (is_lock && st_r.unl)
                    st_nxt.lock = apb_req.pwdata[3:0]; // R1 R2
                // a locked group swallows the write with no error
                else if (is_per && !st_r.lock[per_grp])
                    st_nxt.regs[per_idx] = apb_req.pwdata; // R5
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r         <= '0;
            st_r.lock    <= plk_pkg::RST_LOCK[3:0];
            st_r.regs    <= {plk_pkg::NPER{plk_pkg::RST_PER}};
        end
        else
            st_r <= st_nxt;
    end

    assign pready                     = st_r.pready;
    assign pslverr                    = st_r.pslverr;
    assign prdata                     = st_r.prdata;
    assign peripheral_group_lock_bits = st_r.lock;
    assign lock_bits_open             = st_r.unl;
    assign periph_regs                = st_r.regs;

    // ********************************************
    // checks
    // ********************************************
    lock_write_a: assert property (@(posedge mclk) disable iff (!rst_b) // R1
        done && apb_req.pwrite && is_lock && st_r.unl
        |=> st_r.lock == $past(apb_req.pwdata[3:0]))
        else $error("lock bits not updated while open");

    lock_guard_a: assert property (@(posedge mclk) disable iff (!rst_b) // R2
        !st_r.unl |=> st_r.lock == $past(st_r.lock))
        else $error("lock bits changed while closed");

    open_cause_a: assert property (@(posedge mclk) disable iff (!rst_b) // R2
        $rose(st_r.unl) |-> $past(done && apb_req.pwrite && is_key
        && st_r.idx == 2'(plk_pkg::KEY_LEN - 1)))
        else $error("unlock without final key");

    relock_a: assert property (@(posedge mclk) disable iff (!rst_b) // R3
        done && apb_req.pwrite && is_key && st_r.unl
        |=> !st_r.unl ##1 !st_r.unl)
        else $error("key write did not relock");

    key_read_a: assert property (@(posedge mclk) disable iff (!rst_b) // R4
        acc && !apb_req.pwrite && is_key
        |=> pready && prdata == {31'h0, $past(st_r.unl)})
        else $error("key read wrong state");

    locked_drop_a: assert property (@(posedge mclk) disable iff (!rst_b) // R5
        done && apb_req.pwrite && is_per && st_r.lock[per_grp]
        |=> st_r.regs == $past(st_r.regs) && !pslverr)
        else $error("locked group register changed");

    per_read_a: assert property (@(posedge mclk) disable iff (!rst_b) // R6
        acc && !apb_req.pwrite && is_per
        |=> pready && !pslverr && prdata == $past(st_r.regs[per_idx]))
        else $error("peripheral read wrong");

    bad_key_a: assert property (@(posedge mclk) disable iff (!rst_b) // R7
        done && apb_req.pwrite && is_key && !st_r.unl
        && apb_req.pwdata[7:0] != plk_pkg::KEY_SEQ[st_r.idx]
        |=> !st_r.unl && st_r.idx == 2'h0)
        else $error("bad key not rejected");

    // ********************************************
    // checks on the bus answer and the sequence
    // ********************************************
    ready_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b) // R6
        pready |=> !pready)
        else $error("pready held over one cycle");

    err_ready_a: assert property (@(posedge mclk) disable iff (!rst_b) // R5
        pslverr |-> pready)
        else $error("pslverr without pready");

    map_noerr_a: assert property (@(posedge mclk) disable iff (!rst_b) // R5
        acc && (is_key || is_lock || is_per)
        |=> pready && !pslverr)
        else $error("mapped access answered with error");

    bad_addr_a: assert property (@(posedge mclk) disable iff (!rst_b) // R6
        acc && !(is_key || is_lock || is_per)
        |=> pready && pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");

    read_keep_a: assert property (@(posedge mclk) disable iff (!rst_b) // R6
        done && !apb_req.pwrite
        |=> st_r.regs == $past(st_r.regs) && st_r.lock == $past(st_r.lock)
        && st_r.unl == $past(st_r.unl))
        else $error("read changed state");

    lock_read_a: assert property (@(posedge mclk) disable iff (!rst_b) // R1
        acc && !apb_req.pwrite && is_lock
        |=> prdata == {28'h0, $past(st_r.lock)})
        else $error("lock read wrong");

    seq_step_a: assert property (@(posedge mclk) disable iff (!rst_b) // R2
        done && apb_req.pwrite && is_key && !st_r.unl
        && apb_req.pwdata[7:0] == plk_pkg::KEY_SEQ[st_r.idx]
        && st_r.idx != 2'(plk_pkg::KEY_LEN - 1)
        |=> st_r.idx == $past(st_r.idx) + 2'h1 && !st_r.unl)
        else $error("key step not taken");

    key_hold_a: assert property (@(posedge mclk) disable iff (!rst_b) // R3
        !(done && apb_req.pwrite && is_key)
        |=> st_r.unl == $past(st_r.unl))
        else $error("open state moved without key write");

    grp_open_a: assert property (@(posedge mclk) disable iff (!rst_b) // R5
        done && apb_req.pwrite && is_per && !st_r.lock[per_grp]
        |=> st_r.regs[$past(per_idx)] == $past(apb_req.pwdata))
        else $error("open group write lost");

    closed_lock_a: assert property (@(posedge mclk) disable iff (!rst_b) // R2
        done && apb_req.pwrite && is_lock && !st_r.unl
        |=> st_r.lock == $past(st_r.lock) && !pslverr)
        else $error("closed lock register written");

    idle_quiet_a: assert property (@(posedge mclk) disable iff (!rst_b) // R6
        !apb_req.psel && !pready |=> !pready)
        else $error("pready without a transfer");
endmodule // plk_write_lock

// [common/plk_pkg.sv]
// package: register map, key sequence and carriers for the write lock block
package plk_pkg;
    // ********************************************
    // sizes
    // ********************************************
    localparam int unsigned NGROUP   = 4;
    localparam int unsigned NREG     = 2;
    localparam int unsigned NPER     = NGROUP * NREG;
    localparam int unsigned KEY_LEN  = 2;
    localparam int unsigned AW       = 12;
    localparam int unsigned DW       = 32;
    // ********************************************
    // register map (byte addresses)
    // ********************************************
    localparam logic [11:0] KEY_OFS  = 12'h000;
    localparam logic [11:0] LOCK_OFS = 12'h004;
    localparam logic [11:0] PER_OFS  = 12'h040;
    localparam logic [31:0] RST_LOCK = 32'h0000_000f;
    localparam logic [31:0] RST_PER  = 32'h0000_0000;
    // key values are arbitrary; entry 0 is written first
    localparam logic [KEY_LEN-1:0][7:0] KEY_SEQ = {8'hf1, 8'ha5};
    // ********************************************
    // carriers
    // ********************************************
    typedef struct packed {
        logic            psel;
        logic            penable;
        logic            pwrite;
        logic [AW-1:0]   paddr;
        logic [DW-1:0]   pwdata;
    } plk_apb_req_s;

    typedef struct packed {
        logic [NPER-1:0][DW-1:0] regs;
        logic [NGROUP-1:0]       lock;
        logic                    unl;
        logic [1:0]              idx;
        logic                    pready;
        logic                    pslverr;
        logic [DW-1:0]           prdata;
    } plk_state_s;
endpackage : plk_pkg

// [dv/plk_write_lock_tb_top.sv]
// testbench: apb scenarios for the register write lock block
`timescale 1ns/1ns
module plk_write_lock_tb_top;
    logic                               mclk;
    logic                               rst_b;
    plk_pkg::plk_apb_req_s              req;
    logic                               pready;
    logic                               pslverr;
    logic [31:0]                        prdata;
    logic [3:0]                         lkb;
    logic                               opn;
    logic [plk_pkg::NPER-1:0][31:0]     regs;
    logic [31:0]                        rv;
    logic                               ev;
    int                                 n_fail = 0;
    int                                 num_checks = 0;
    plk_write_lock dut (.mclk(mclk), .rst_b(rst_b), .apb_req(req),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .peripheral_group_lock_bits(lkb), .lock_bits_open(opn),
        .periph_regs(regs));
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // ********************************************
    // shared tasks
    // ********************************************
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // pready is sampled at the rising edge itself, as the slave sees it;
    // the request is released only after that edge
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        int i;
        @(posedge mclk);
        req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
        @(posedge mclk);
        req.penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge mclk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1)
        begin
            n_fail++;
            end_sim();
        end
        rv = prdata;
        ev = pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(rv, e);
    endtask
    // ********************************************
    // scenarios
    // ********************************************
    task automatic t_key;
        chk({28'h0, lkb}, 32'hf);
        rd(plk_pkg::KEY_OFS, 32'h0);
        apb(plk_pkg::LOCK_OFS, 1'b1, 32'h0);
        rd(plk_pkg::LOCK_OFS, 32'hf);
        apb(plk_pkg::KEY_OFS, 1'b1, {24'h0, plk_pkg::KEY_SEQ[0]});
        apb(plk_pkg::KEY_OFS, 1'b1, 32'h0);
        apb(plk_pkg::KEY_OFS, 1'b1, {24'h0, plk_pkg::KEY_SEQ[1]});
        rd(plk_pkg::KEY_OFS, 32'h0);
        apb(plk_pkg::LOCK_OFS, 1'b1, 32'h0);
        rd(plk_pkg::LOCK_OFS, 32'hf);
        apb(plk_pkg::KEY_OFS, 1'b1, {24'h0, plk_pkg::KEY_SEQ[0]});
        apb(plk_pkg::KEY_OFS, 1'b1, {24'h0, plk_pkg::KEY_SEQ[1]});
        rd(plk_pkg::KEY_OFS, 32'h1);
        chk({31'h0, opn}, 32'h1);
        apb(plk_pkg::LOCK_OFS, 1'b1, 32'he);
        rd(plk_pkg::LOCK_OFS, 32'he);
        chk({28'h0, lkb}, 32'he);
        apb(plk_pkg::KEY_OFS, 1'b1, 32'h0);
        rd(plk_pkg::KEY_OFS, 32'h0);
        chk({31'h0, opn}, 32'h0);
        apb(plk_pkg::LOCK_OFS, 1'b1, 32'h0);
        rd(plk_pkg::LOCK_OFS, 32'he);
        $display("test key done");
    endtask
    task automatic t_group;
        apb(plk_pkg::PER_OFS, 1'b1, 32'h0000_cafe);
        rd(plk_pkg::PER_OFS, 32'h0000_cafe);
        chk(regs[0], 32'h0000_cafe);
        chk({31'h0, ev}, 32'h0);
        apb(plk_pkg::PER_OFS + 12'h008, 1'b1, 32'h0000_beef);
        chk({31'h0, ev}, 32'h0);
        rd(plk_pkg::PER_OFS + 12'h008, 32'h0);
        apb(12'h800, 1'b0, 32'h0);
        chk({31'h0, ev}, 32'h1);
        $display("test group done");
    endtask
    task automatic t_reset;
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        chk({28'h0, lkb}, 32'hf);
        chk({31'h0, opn}, 32'h0);
        chk(regs[0], 32'h0);
        rd(plk_pkg::LOCK_OFS, 32'hf);
        $display("test reset done");
    endtask
    initial
    begin
        req   = '0;
        rst_b = 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        t_key();
        t_group();
        t_reset();
        end_sim();
    end
endmodule // plk_write_lock_tb_top
